// >>> mprot_top.sv
// Motor protection mode select, cutoff override and gate output forcing.
// Assumes APB master on pclk; trip inputs synchronous to pclk.
// How it works
// (RQ1) Bit 6 picks cutoff trigger: overcurrent pulse, or comparator one rising edge.
// (RQ2) Cycle-by-cycle mode cuts PWM on overcurrent pulse, restores at next period.
// (RQ3) If overcurrent persists at restore, cut again at once.
// (RQ4) Bit 4 selects software trip as fault or pause behaviour.
// (RQ5) Limit restart 0: PWM resumes as soon as limit trip clears.
// (RQ6) Limit restart 1: PWM held off until next period start after clearing.
// (RQ7) Bit 2 selects overcurrent pulse trip as fault or pause behaviour.
// (RQ8) Stall compare mode bit means pause at 1; software sets it first.
// (RQ9) Stall overflow mode bit means pause at 1; software sets it first.
// (RQ10) Six override bits give gate levels during cutoff, C low down to A high.
// (RQ11) Unused top bits of both registers read as zero.
// (RQ12) During cutoff gate outputs follow override bits, not the polarity stage.
// (RQ13) Fault clears itself when source ends; pause holds until software release.
// (RQ14) Cutoff stays latched until software releases it; pulses are latched.
// (RQ15) Protection forces brake (lows on) or free run (all off).
// (RQ16) Period start pulse times deferred restarts.
// (RQ17) Registers reached over APB; writes act the next cycle.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module mprot_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Trip sources
    input  wire logic        overcurrent_pulse,
    input  wire logic        current_limit_trip,
    input  wire logic        stall_compare_trip,
    input  wire logic        stall_overflow_trip,
    input  wire logic        comparator_one_out,
    input  wire logic        pwm_period_start,
    // Polarity stage drive, bits C low down to A high
    input  wire logic [5:0]  polarity_drive,
    // Gate driver outputs
    output logic             phase_a_high_drive,
    output logic             phase_a_low_drive,
    output logic             phase_b_high_drive,
    output logic             phase_b_low_drive,
    output logic             phase_c_high_drive,
    output logic             phase_c_low_drive,
    // Interrupt
    output logic             irq
);
    logic [7:0]  protection_mode_select;
    logic [7:0]  cutoff_output_levels;
    logic [7:0]  control;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic        fast_current_cutoff;
    logic        cbc_off;
    logic        lim_hold;
    logic        prev_cut_hw_en;
    logic        prev_cut_sw;
    logic        prev_sw_trip;
    logic        prev_protect;
    logic        prev_cbc;
    logic        cmp_rise;
    logic        cut_trigger;
    logic        sw_release;
    logic        protect;
    logic        lim_active;
    logic        wr;
    logic        rd;
    logic        prev_cut;
    // Protect source count
    localparam int SRC_N_W = mprot_pkg::SRC_N;
    logic [SRC_N_W-1:0] src_active;
    logic [SRC_N_W-1:0] src_trip;
    logic [SRC_N_W-1:0] src_en;
    logic [SRC_N_W-1:0] src_pause;
    logic [5:0]  next_gate;
    logic [2:0]  events;
    logic [31:0] next_rdata;

    // APB decode, zero wait states
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    // Register writes, unused bits kept at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protection_mode_select <= mprot_pkg::MODE_RESET;
            cutoff_output_levels   <= mprot_pkg::LEVELS_RESET;
            control                <= mprot_pkg::CTL_RESET;
            irq_mask               <= 3'h0;
        end else if (wr) begin
            case (paddr)
                mprot_pkg::ADDR_MODE:    protection_mode_select <= pwdata[7:0]
                                                                   & mprot_pkg::MODE_MASK;
                mprot_pkg::ADDR_LEVELS:  cutoff_output_levels <= pwdata[7:0]
                                                                 & mprot_pkg::LEVELS_MASK;
                mprot_pkg::ADDR_CONTROL: control <= pwdata[7:0];
                mprot_pkg::ADDR_MASK:    irq_mask <= pwdata[2:0];
                default: ;
            endcase // see (RQ17) (RQ11)
        end
    end

    // Read mux, data registered in the setup cycle
    always_comb begin
        next_rdata = 32'h0;
        case (paddr)
            mprot_pkg::ADDR_MODE:    next_rdata = {24'h0, protection_mode_select}; // see (RQ11)
            mprot_pkg::ADDR_LEVELS:  next_rdata = {24'h0, cutoff_output_levels};
            mprot_pkg::ADDR_CONTROL: next_rdata = {24'h0, control};
            mprot_pkg::ADDR_STATUS:  next_rdata = {28'h0, lim_hold, cbc_off,
                                                   fast_current_cutoff, protect};
            mprot_pkg::ADDR_IRQ:     next_rdata = {29'h0, irq_status};
            mprot_pkg::ADDR_MASK:    next_rdata = {29'h0, irq_mask};
            default:                 next_rdata = 32'h0;
        endcase
    end

    // Answer in the access cycle; unmapped or unaligned address flags an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr > mprot_pkg::ADDR_MASK || paddr[1:0] != 2'h0);
            if (rd) begin
                prdata <= next_rdata;
            end
        end
    end

    // Previous values for software edge sensing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_cut_hw_en <= 1'b0;
            prev_cut_sw    <= 1'b0;
            prev_sw_trip   <= 1'b0;
        end else begin
            prev_cut_hw_en <= control[mprot_pkg::CTL_CUT_HW_EN];
            prev_cut_sw    <= control[mprot_pkg::CTL_CUT_SW];
            prev_sw_trip   <= control[mprot_pkg::CTL_SW_TRIP];
        end
    end

    mprot_edge u_cmp_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .level   (comparator_one_out),
        .rise    (cmp_rise)
    );

    // Cutoff trigger source
    assign cut_trigger = protection_mode_select[mprot_pkg::MODE_TRIG_SRC]
                         ? cmp_rise : overcurrent_pulse; // see (RQ1)

    // Fast cutoff: latched, released only by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_current_cutoff <= 1'b0;
        end else if (control[mprot_pkg::CTL_CUT_HW_EN] && cut_trigger) begin
            fast_current_cutoff <= 1'b1; // see (RQ14)
        end else if (control[mprot_pkg::CTL_CUT_SW]) begin
            fast_current_cutoff <= 1'b1;
        end else if ((control[mprot_pkg::CTL_CUT_HW_EN] && !prev_cut_hw_en)
                     || (prev_cut_sw && !control[mprot_pkg::CTL_CUT_SW])) begin
            fast_current_cutoff <= 1'b0; // see (RQ14)
        end
    end

    // Software release of pause sources: trip bit falling
    assign sw_release = prev_sw_trip && !control[mprot_pkg::CTL_SW_TRIP];

    assign src_trip[mprot_pkg::SRC_OC]   = overcurrent_pulse;
    assign src_trip[mprot_pkg::SRC_SCMP] = stall_compare_trip;
    assign src_trip[mprot_pkg::SRC_SOVF] = stall_overflow_trip;
    assign src_trip[mprot_pkg::SRC_SW]   = control[mprot_pkg::CTL_SW_TRIP];
    assign src_en[mprot_pkg::SRC_OC]     = control[mprot_pkg::CTL_OC_EN];
    assign src_en[mprot_pkg::SRC_SCMP]   = control[mprot_pkg::CTL_STCMP_EN];
    assign src_en[mprot_pkg::SRC_SOVF]   = control[mprot_pkg::CTL_STOVF_EN];
    assign src_en[mprot_pkg::SRC_SW]     = 1'b1;
    assign src_pause[mprot_pkg::SRC_OC]   = protection_mode_select[mprot_pkg::MODE_OC]; // see (RQ7)
    assign src_pause[mprot_pkg::SRC_SCMP] =
        protection_mode_select[mprot_pkg::MODE_STALL_CMP]; // see (RQ8)
    assign src_pause[mprot_pkg::SRC_SOVF] =
        protection_mode_select[mprot_pkg::MODE_STALL_OVF]; // see (RQ9)
    assign src_pause[mprot_pkg::SRC_SW]   = protection_mode_select[mprot_pkg::MODE_SW]; // see (RQ4)

    // One latch per protect source
    genvar gi;
    generate
        for (gi = 0; gi < SRC_N_W; gi++) begin : g_src
            mprot_latch u_latch (
                .pclk        (pclk),
                .presetn     (presetn),
                .enable      (src_en[gi]),
                .trip        (src_trip[gi]),
                .pause_mode  (src_pause[gi]),
                .release_req (sw_release),
                .active      (src_active[gi])
            );
        end
    endgenerate

    assign protect = |src_active;

    // Cycle-by-cycle cut: set by pulse, cleared at period start unless pulse persists
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cbc_off <= 1'b0;
        end else if (!protection_mode_select[mprot_pkg::MODE_CBC]) begin
            cbc_off <= 1'b0;
        end else if (overcurrent_pulse) begin
            cbc_off <= 1'b1; // see (RQ2) (RQ3)
        end else if (pwm_period_start) begin
            cbc_off <= 1'b0; // see (RQ2) (RQ16)
        end
    end

    // Current limit hold
    assign lim_active = control[mprot_pkg::CTL_LIM_EN] && current_limit_trip;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lim_hold <= 1'b0;
        end else if (lim_active) begin
            lim_hold <= 1'b1;
        end else if (!protection_mode_select[mprot_pkg::MODE_LIM_RST]) begin
            lim_hold <= 1'b0; // see (RQ5)
        end else if (pwm_period_start) begin
            lim_hold <= 1'b0; // see (RQ6) (RQ16)
        end
    end

    // Gate output selection, bits C low down to A high
    always_comb begin
        if (fast_current_cutoff) begin
            next_gate = cutoff_output_levels[5:0]; // see (RQ12) (RQ10)
        end else if (protect) begin
            next_gate = control[mprot_pkg::CTL_BRAKE] ? 6'h2A : 6'h00; // see (RQ15)
        end else if (cbc_off || lim_hold || lim_active) begin
            next_gate = 6'h00;
        end else begin
            next_gate = polarity_drive;
        end
    end

    // Gate outputs straight from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {phase_c_low_drive, phase_c_high_drive, phase_b_low_drive,
             phase_b_high_drive, phase_a_low_drive, phase_a_high_drive} <= 6'h00;
        end else begin
            {phase_c_low_drive, phase_c_high_drive, phase_b_low_drive,
             phase_b_high_drive, phase_a_low_drive, phase_a_high_drive} <= next_gate;
        end
    end

    // Interrupt events: rising edges of protect, cutoff, cycle cut
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_protect <= 1'b0;
            prev_cbc     <= 1'b0;
        end else begin
            prev_protect <= protect;
            prev_cbc     <= cbc_off;
        end
    end
    assign events = {cbc_off & ~prev_cbc, fast_current_cutoff & ~prev_cut,
                     protect & ~prev_protect};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_cut <= 1'b0;
        end else begin
            prev_cut <= fast_current_cutoff;
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= (irq_status & ~((wr && paddr == mprot_pkg::ADDR_IRQ) ? pwdata[2:0]
                                                                              : 3'h0))
                          | events;
        end
    end

    // Interrupt level, one cycle behind status and mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end
endmodule : mprot_top

// >>> mprot_pkg.sv
// Package for the motor protection mode and cutoff override block.
// Assumes an APB slave with 32-bit data and one word per register.
package mprot_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_MODE    = 8'h00;
    localparam logic [7:0] ADDR_LEVELS  = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ     = 8'h10;
    localparam logic [7:0] ADDR_MASK    = 8'h14;
    // Mode register fields
    localparam int MODE_STALL_OVF = 0;
    localparam int MODE_STALL_CMP = 1;
    localparam int MODE_OC        = 2;
    localparam int MODE_LIM_RST   = 3;
    localparam int MODE_SW        = 4;
    localparam int MODE_CBC       = 5;
    localparam int MODE_TRIG_SRC  = 6;
    localparam logic [7:0] MODE_MASK   = 8'h7F;
    localparam logic [7:0] LEVELS_MASK = 8'h3F;
    localparam logic [7:0] MODE_RESET   = 8'h00;
    localparam logic [7:0] LEVELS_RESET = 8'h00;
    // Control register fields
    localparam int CTL_OC_EN      = 0;
    localparam int CTL_LIM_EN     = 1;
    localparam int CTL_STCMP_EN   = 2;
    localparam int CTL_STOVF_EN   = 3;
    localparam int CTL_SW_TRIP    = 4;
    localparam int CTL_CUT_HW_EN  = 5;
    localparam int CTL_CUT_SW     = 6;
    localparam int CTL_BRAKE      = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // Status and event fields
    localparam int ST_PROTECT = 0;
    localparam int ST_CUTOFF  = 1;
    localparam int ST_CBC_OFF = 2;
    localparam int ST_LIM_OFF = 3;
    localparam int EV_PROTECT = 0;
    localparam int EV_CUTOFF  = 1;
    localparam int EV_CBC     = 2;
    localparam int EV_WIDTH   = 3;
    // Protect source indices
    localparam int SRC_OC   = 0;
    localparam int SRC_SCMP = 1;
    localparam int SRC_SOVF = 2;
    localparam int SRC_SW   = 3;
    localparam int SRC_N    = 4;
endpackage : mprot_pkg

// >>> mprot_latch.sv
// One protect source latch with fault or pause release.
// Assumes synchronous trip and release inputs on pclk.
`timescale 1ns/1ps
module mprot_latch (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Source
    input  wire logic enable,
    input  wire logic trip,
    input  wire logic pause_mode,
    input  wire logic release_req,
    // State
    output logic      active
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active <= 1'b0;
        end else if (enable && trip) begin
            active <= 1'b1;
        end else if (!enable) begin
            active <= 1'b0;
        end else if (!pause_mode) begin
            active <= 1'b0; // see (RQ13)
        end else if (release_req) begin
            active <= 1'b0; // see (RQ13)
        end
    end
endmodule : mprot_latch

// >>> mprot_edge.sv
// Rising edge detector for a synchronous level.
// Assumes the input is already in the pclk domain.
`timescale 1ns/1ps
module mprot_edge (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Level in, pulse out
    input  wire logic level,
    output logic      rise
);
    logic prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end
    assign rise = level & ~prev;
endmodule : mprot_edge

// >>> mprot_checker.sv
// Checker: register bus answers and gate forcing of mprot_top.
// Assumes a bind onto mprot_top; sees only its ports.
`timescale 1ns/1ps
module mprot_checker (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Sources and gates
    input wire logic        overcurrent_pulse,
    input wire logic [5:0]  polarity_drive,
    input wire logic        phase_a_high_drive,
    input wire logic        phase_a_low_drive,
    input wire logic        phase_b_high_drive,
    input wire logic        phase_b_low_drive,
    input wire logic        phase_c_high_drive,
    input wire logic        phase_c_low_drive
);
    logic [5:0] gate;
    logic [7:0] mode, lv, ctl;
    logic [1:0] up;
    logic       hw, seen;
    assign gate = {phase_c_low_drive, phase_c_high_drive, phase_b_low_drive,
                   phase_b_high_drive, phase_a_low_drive, phase_a_high_drive};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow copies of written registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= 8'h00;
            lv   <= 8'h00;
            ctl  <= 8'h00;
        end else if (psel && penable && pwrite && pready) begin
            if (paddr == mprot_pkg::ADDR_MODE) mode <= pwdata[7:0];
            if (paddr == mprot_pkg::ADDR_LEVELS) lv <= pwdata[7:0];
            if (paddr == mprot_pkg::ADDR_CONTROL) ctl <= pwdata[7:0];
        end
    end
    // Cycles since reset and sticky history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up   <= 2'h0;
            hw   <= 1'b0;
            seen <= 1'b0;
        end else begin
            up   <= up + {1'b0, up != 2'h3};
            hw   <= hw | ctl[5];
            seen <= seen | ctl[5] | ctl[1] | mode[5];
        end
    end
    property p_ready;
        psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_slverr;
        psel && penable && paddr > mprot_pkg::ADDR_MASK |-> pslverr;
    endproperty
    a_slverr: assert property (p_slverr) else $error("no slverr");
    property p_rd_mode;
        psel && penable && !pwrite && paddr == 8'h00 |-> prdata[31:7] == 25'h0;
    endproperty
    a_rd_mode: assert property (p_rd_mode) else $error("mode top bits");
    property p_rd_lv;
        psel && penable && !pwrite && paddr == 8'h04 |-> prdata[31:6] == 26'h0;
    endproperty
    a_rd_lv: assert property (p_rd_lv) else $error("level top bits");
    property p_cut;
        ctl[6] && $past(ctl[6], 3) && lv == $past(lv, 3) |-> gate == lv[5:0];
    endproperty
    a_cut: assert property (p_cut) else $error("cutoff levels");
    property p_brake;
        !seen && ctl[4] && $past(ctl[4], 3) && !ctl[6] && !$past(ctl[6], 3)
            && ctl[7] == $past(ctl[7], 3) |-> gate == {3{ctl[7], 1'b0}};
    endproperty
    a_brake: assert property (p_brake) else $error("brake pattern");
    property p_pass;
        up == 2'h3 && !seen && ctl == 8'h00 && $past(ctl, 3) == 8'h00
            |-> gate == $past(polarity_drive);
    endproperty
    a_pass: assert property (p_pass) else $error("normal drive");
    property p_cbc;
        !hw && ctl == 8'h00 && mode[5] && overcurrent_pulse |-> ##[1:2] gate == 6'h00;
    endproperty
    a_cbc: assert property (p_cbc) else $error("cycle cut");
endmodule : mprot_checker

bind mprot_top mprot_checker u_mprot_checker (.*);

// >>> mprot_gate_model.sv
// Model of the external gate driver and power stage.
// Assumes active-high gate lines: one turns a transistor on.
`timescale 1ns/1ps
module mprot_gate_model (
    // Gate lines
    input wire logic  phase_a_high_drive,
    input wire logic  phase_a_low_drive,
    input wire logic  phase_b_high_drive,
    input wire logic  phase_b_low_drive,
    input wire logic  phase_c_high_drive,
    input wire logic  phase_c_low_drive,
    // Power stage state
    output logic [2:0] low_clamped,
    output logic       shoot_through
);
    // Phase tied to ground by its low side alone
    assign low_clamped = {phase_c_low_drive & !phase_c_high_drive,
                          phase_b_low_drive & !phase_b_high_drive,
                          phase_a_low_drive & !phase_a_high_drive};
    assign shoot_through = (phase_a_high_drive & phase_a_low_drive)
                         | (phase_b_high_drive & phase_b_low_drive)
                         | (phase_c_high_drive & phase_c_low_drive);
endmodule : mprot_gate_model

// >>> test_motor_protection_mode_and_override.sv
// Testbench: registers, trip sources and gate forcing of mprot_top.
// Assumes the gate driver model and the bound checker.
`timescale 1ns/1ps
module test_motor_protection_mode_and_override;
    localparam logic [7:0] AM = mprot_pkg::ADDR_MODE;
    localparam logic [7:0] AL = mprot_pkg::ADDR_LEVELS;
    localparam logic [7:0] AC = mprot_pkg::ADDR_CONTROL;
    localparam logic [7:0] AI = mprot_pkg::ADDR_IRQ;
    localparam logic [7:0] AK = mprot_pkg::ADDR_MASK;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv, d;
    logic        pready, pslverr, irq, ev, shoot_through;
    logic        overcurrent_pulse = 1'b0, current_limit_trip = 1'b0;
    logic        stall_compare_trip = 1'b0, stall_overflow_trip = 1'b0;
    logic        comparator_one_out = 1'b0, pwm_period_start = 1'b0;
    logic [5:0]  polarity_drive = 6'h00, p, lv, gate;
    logic [2:0]  low_clamped;
    logic        phase_a_high_drive, phase_a_low_drive, phase_b_high_drive;
    logic        phase_b_low_drive, phase_c_high_drive, phase_c_low_drive;
    int          bad_count = 0, tests_run = 0;
    assign gate = {phase_c_low_drive, phase_c_high_drive, phase_b_low_drive,
                   phase_b_high_drive, phase_a_low_drive, phase_a_high_drive};
    always #20 pclk = ~pclk;
    mprot_top u_mprot_top (.*);
    mprot_gate_model u_mprot_gate_model (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            bad_count++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) bad_count++;
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic gchk(input logic [5:0] e);
        repeat (4) @(posedge pclk);
        chk({26'h0, gate}, {26'h0, e});
    endtask : gchk
    task automatic src(input int i, input logic v);
        @(posedge pclk);
        case (i)
            0: overcurrent_pulse <= v;
            1: current_limit_trip <= v;
            2: stall_compare_trip <= v;
            3: stall_overflow_trip <= v;
            4: comparator_one_out <= v;
            5: pwm_period_start <= v;
            default: begin
                overcurrent_pulse <= v;
                pwm_period_start <= v;
            end
        endcase
    endtask : src
    function automatic logic [5:0] brk(input logic b);
        return b ? 6'h2A : 6'h00;
    endfunction : brk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #2_000_000;
        bad_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(85655));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, AM, 0);
        chk(rv, {24'h0, mprot_pkg::MODE_RESET});
        apb(0, AL, 0);
        chk(rv, {24'h0, mprot_pkg::LEVELS_RESET});
        apb(1, 8'h3C, 32'hFFFF_FFFF);
        chk({31'h0, ev}, 32'h1);
        apb(0, 8'h3C, 0);
        chk(rv, 32'h0);
        apb(0, 8'h06, 0);
        chk({31'h0, ev}, 32'h1);
        repeat (6) begin
            p = 6'($urandom);
            polarity_drive <= p;
            gchk(p);
        end
        p = 6'h15;
        polarity_drive <= p;
        repeat (6) begin
            d = $urandom & 32'hFFFF_FFDF;
            for (int i = 0; i < 2; i++) begin
                apb(1, i ? AL : AM, d);
                apb(0, i ? AL : AM, 0);
                chk(rv, d & (i ? 32'h3F : 32'h7F));
            end
        end
        // Overcurrent trip: fault or pause, free run or brake
        for (int m = 0; m < 4; m++) begin
            apb(1, AM, m[0] ? 32'h04 : 32'h00);
            apb(1, AC, {24'h0, m[1], 7'h01});
            src(0, 1);
            src(0, 0);
            gchk(m[0] ? brk(m[1]) : p);
            apb(1, AC, 32'h10);
            apb(1, AC, 0);
            gchk(p);
        end
        apb(0, AI, 0);
        chk(rv, 32'h1);
        apb(1, AK, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1, AI, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // Stall sources, pause mode set first
        for (int s = 0; s < 2; s++) begin
            apb(1, AM, s ? 32'h01 : 32'h02);
            apb(1, AC, s ? 32'h88 : 32'h84);
            src(2 + s, 1);
            src(2 + s, 0);
            gchk(6'h2A);
            apb(1, AC, 32'h10);
            apb(1, AC, 0);
            gchk(p);
        end
        apb(1, AC, 32'h90);
        gchk(6'h2A);
        chk({29'h0, low_clamped}, 32'h7);
        chk({31'h0, shoot_through}, 32'h0);
        apb(1, AC, 0);
        gchk(p);
        // Current limit, immediate or deferred restart
        for (int r = 0; r < 2; r++) begin
            apb(1, AM, r ? 32'h08 : 32'h00);
            apb(1, AC, 32'h02);
            src(1, 1);
            gchk(6'h00);
            src(1, 0);
            gchk(r ? 6'h00 : p);
            src(5, 1);
            src(5, 0);
            gchk(p);
        end
        apb(1, AC, 0);
        apb(1, AM, 32'h20);
        src(0, 1);
        src(0, 0);
        gchk(6'h00);
        src(6, 1);
        src(6, 0);
        gchk(6'h00);
        src(5, 1);
        src(5, 0);
        gchk(p);
        apb(1, AM, 0);
        lv = 6'($urandom) ^ 6'h2A;
        apb(1, AL, {26'h0, lv});
        apb(1, AC, 32'h40);
        gchk(lv);
        apb(0, mprot_pkg::ADDR_STATUS, 0);
        chk(rv, 32'h2);
        apb(0, AI, 0);
        chk(rv, 32'h7);
        apb(1, AC, 0);
        gchk(p);
        for (int t = 0; t < 2; t++) begin
            apb(1, AM, t ? 32'h40 : 32'h00);
            apb(1, AC, 32'h20);
            src(t ? 0 : 4, 1);
            src(t ? 0 : 4, 0);
            gchk(p);
            src(t ? 4 : 0, 1);
            src(t ? 4 : 0, 0);
            gchk(lv);
            gchk(lv);
            apb(1, AC, 0);
            apb(1, AC, 32'h20);
            gchk(p);
        end
        end_of_test();
    end
endmodule : test_motor_protection_mode_and_override
